// file: logic/hco_pkg.sv
package hco_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_START = 8'h00;
  localparam logic [7:0] OFS_WRAP = 8'h04;
  localparam logic [7:0] OFS_DIMS = 8'h08;
  localparam logic [7:0] OFS_COLOR1 = 8'h0C;
  localparam logic [7:0] OFS_COLOR2 = 8'h10;
  localparam logic [7:0] OFS_POSEN = 8'h14;
  localparam logic [7:0] OFS_LOWY = 8'h18;
  localparam logic [7:0] OFS_BLINK1 = 8'h1C;
  localparam logic [7:0] OFS_BLINK2 = 8'h20;
  localparam logic [7:0] OFS_BLINKCTL = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;

  // field positions
  localparam int POS_STEP = 0;
  localparam int POS_WIDTH = 8;
  localparam int POS_UHEIGHT = 16;
  localparam int POS_LHEIGHT = 24;
  localparam int POS_HPOS = 0;
  localparam int POS_VPOS = 16;
  localparam int POS_EN = 31;
  localparam int POS_BLINK_EN = 8;

  // reset values
  localparam logic [31:0] RST_REG = 32'h0000_0000;
  localparam logic [23:0] RST_COLOR = 24'h00_0000;

  localparam int CNT_W = 11;
  localparam int PIX_W = 24;
  localparam int PIX_PER_WORD = 16;

  typedef struct packed {
    logic valid;
    logic line_start;
    logic frame_end;
    logic [CNT_W-1:0] hcount;
    logic [CNT_W-1:0] vcount;
    logic [PIX_W-1:0] pixel;
  } hco_vid_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } hco_mem_rsp_s;

  typedef enum logic [1:0] {FT_IDLE, FT_FETCH, FT_READY} hco_fetch_e;
endpackage

// file: logic/hco_cursor.sv
// Behaviour
// - cursor masters its own memory reads, at the start of the video line in which it is shown.
// - image is two bits per pixel, stored linearly, size from width and height.
// - code 00 passes, 01 inverts, 10 first colour, 11 second colour.
// - sixteen pixels per word, pixel 0 in bits 1:0, shown ascending.
// - position matching the counters starts cursor overlay.
// - fetch starts at start address, continues from wrap address after last line.
// - dual scan jumps to wrap at upper carry, back to start at lower carry.
// - width and step independent; offset start shows partial cursor, x must match a valid pixel.
// - line step field advances one to four words per cursor line.
// - width field selects 16, 32, 48 or 64 shown pixels.
// - upper height field is lines minus one, upper half only in dual scan.
// - lower height field sets lower-half height, used only in dual scan.
// - cursor clipped at right edge and bottom of active screen.
// - new positions take effect only from the next frame.
// - in dual scan lower-half vertical position sets lower-half start line.
// - blink toggles at 50% duty over programmed frames, swapping blink colours.
// - overlay enable bit set to one enables cursor, zero disables overlay.
// - first colour for code 2, second colour for code 3.
// - updated positions take effect at end of frame.
module hco_cursor #(
  parameter int ADDR_W = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire hco_pkg::hco_mem_rsp_s mem_rsp,
  input wire hco_pkg::hco_vid_s vid_in,
  input wire logic dual_scan,
  input wire logic [hco_pkg::CNT_W-1:0] h_active_end,
  input wire logic [hco_pkg::CNT_W-1:0] v_active_end,
  output logic out_valid,
  output logic [hco_pkg::PIX_W-1:0] out_pixel
);
  logic [31:0] start_addr;
  logic [31:0] wrap_addr;
  logic [31:0] dims;
  logic [23:0] color1;
  logic [23:0] color2;
  logic [31:0] pos_en;
  logic [10:0] low_y;
  logic [23:0] blink1;
  logic [23:0] blink2;
  logic [8:0] blink_ctl;
  logic [10:0] sh_x;
  logic [10:0] sh_y;
  logic [10:0] sh_ly;
  logic sh_en;
  logic row_on;
  logic [5:0] row_cnt;
  logic lower_phase;
  logic [31:0] base_addr;
  logic [31:0] line_addr;
  hco_pkg::hco_fetch_e fetch_st;
  logic [1:0] word_idx;
  logic [31:0] line_buf [4];
  logic show_q;
  logic [5:0] col;
  logic [7:0] blink_cnt;
  logic blink_phase;
  logic show_on;
  logic last_col;

  wire logic [1:0] step_f = dims[hco_pkg::POS_STEP +: 2];
  wire logic [1:0] width_f = dims[hco_pkg::POS_WIDTH +: 2];
  wire logic [5:0] uheight_f = dims[hco_pkg::POS_UHEIGHT +: 6];
  wire logic [5:0] lheight_f = dims[hco_pkg::POS_LHEIGHT +: 6];
  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pready && pwrite;

  // apb: one access cycle, data prepared in setup
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready <= 1'b0;
    end else begin
      pready <= setup;
    end
  end

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    rd_mux = hco_pkg::RST_REG;
    unique case (paddr[7:0])
      hco_pkg::OFS_START: rd_mux = start_addr;
      hco_pkg::OFS_WRAP: rd_mux = wrap_addr;
      hco_pkg::OFS_DIMS: rd_mux = dims;
      hco_pkg::OFS_COLOR1: rd_mux = {8'h00, color1};
      hco_pkg::OFS_COLOR2: rd_mux = {8'h00, color2};
      hco_pkg::OFS_POSEN: rd_mux = pos_en;
      hco_pkg::OFS_LOWY: rd_mux = {21'h00_0000, low_y};
      hco_pkg::OFS_BLINK1: rd_mux = {8'h00, blink1};
      hco_pkg::OFS_BLINK2: rd_mux = {8'h00, blink2};
      hco_pkg::OFS_BLINKCTL: rd_mux = {23'h00_0000, blink_ctl};
      hco_pkg::OFS_STATUS: rd_mux = {19'h0_0000, fetch_st == hco_pkg::FT_READY, show_q,
                                     lower_phase, blink_phase, row_on, 2'b00, row_cnt};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= hco_pkg::RST_REG;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? hco_pkg::RST_REG : rd_mux;
      pslverr <= !rd_hit || (pwrite && paddr[7:0] == hco_pkg::OFS_STATUS);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      start_addr <= hco_pkg::RST_REG;
      wrap_addr <= hco_pkg::RST_REG;
      dims <= hco_pkg::RST_REG;
      color1 <= hco_pkg::RST_COLOR;
      color2 <= hco_pkg::RST_COLOR;
      pos_en <= hco_pkg::RST_REG;
      low_y <= 11'h000;
      blink1 <= hco_pkg::RST_COLOR;
      blink2 <= hco_pkg::RST_COLOR;
      blink_ctl <= 9'h000;
    end else if (wr_en) begin
      unique case (paddr[7:0])
        hco_pkg::OFS_START: start_addr <= {pwdata[31:2], 2'b00};
        hco_pkg::OFS_WRAP: wrap_addr <= {pwdata[31:2], 2'b00};
        hco_pkg::OFS_DIMS: dims <= pwdata & 32'h3F3F_0303;
        hco_pkg::OFS_COLOR1: color1 <= pwdata[23:0];
        hco_pkg::OFS_COLOR2: color2 <= pwdata[23:0];
        hco_pkg::OFS_POSEN: pos_en <= pwdata & 32'h87FF_07FF;
        hco_pkg::OFS_LOWY: low_y <= pwdata[10:0];
        hco_pkg::OFS_BLINK1: blink1 <= pwdata[23:0];
        hco_pkg::OFS_BLINK2: blink2 <= pwdata[23:0];
        hco_pkg::OFS_BLINKCTL: blink_ctl <= pwdata[8:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sh_x <= 11'h000;
      sh_y <= 11'h000;
      sh_ly <= 11'h000;
      sh_en <= 1'b0;
    end else if (vid_in.frame_end) begin
      sh_x <= pos_en[hco_pkg::POS_HPOS +: 11];
      sh_y <= pos_en[hco_pkg::POS_VPOS +: 11];
      sh_ly <= low_y;
      sh_en <= pos_en[hco_pkg::POS_EN];
    end
  end

  // vertical match picks the half being served
  wire logic [10:0] match_y = lower_phase ? sh_ly : sh_y;
  // no new row when disabled or below screen
  wire logic row_hit = !row_on && sh_en && vid_in.vcount == match_y &&
                       vid_in.vcount <= v_active_end;
  wire logic row_go = vid_in.line_start && (row_on || row_hit) && sh_en;
  // lower height only matters in dual scan
  wire logic [5:0] height_lim = (dual_scan && lower_phase) ? lheight_f : uheight_f;
  wire logic last_ack = fetch_st == hco_pkg::FT_FETCH && mem_rsp.ack && word_idx == width_f;

  // step field plus one words (4 bytes each) added per cursor line
  wire logic [31:0] step_bytes = {27'h000_0000, step_f + 3'd1, 2'b00};

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      row_on <= 1'b0;
      row_cnt <= 6'h00;
      lower_phase <= 1'b0;
      base_addr <= hco_pkg::RST_REG;
      line_addr <= hco_pkg::RST_REG;
    end else if (vid_in.frame_end) begin
      row_on <= 1'b0;
      row_cnt <= 6'h00;
      lower_phase <= 1'b0;
      base_addr <= start_addr;
    end else if (row_go && row_hit) begin
      line_addr <= base_addr;
    end else if (last_ack) begin
      line_addr <= line_addr + step_bytes;
      if (row_cnt == height_lim) begin
        row_on <= 1'b0;
        row_cnt <= 6'h00;
        // carry swaps the address used for the next half
        base_addr <= lower_phase ? start_addr : wrap_addr;
        lower_phase <= dual_scan ? !lower_phase : 1'b0;
      end else begin
        row_on <= 1'b1;
        row_cnt <= row_cnt + 6'h01;
      end
    end
  end

  // line fetched at line start, before x match
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fetch_st <= hco_pkg::FT_IDLE;
      word_idx <= 2'b00;
      mem_req <= 1'b0;
      mem_addr <= hco_pkg::RST_REG;
    end else if (vid_in.frame_end) begin
      fetch_st <= hco_pkg::FT_IDLE;
      mem_req <= 1'b0;
    end else if (row_go && fetch_st != hco_pkg::FT_FETCH) begin
      fetch_st <= hco_pkg::FT_FETCH;
      word_idx <= 2'b00;
      mem_req <= 1'b1;
      mem_addr <= row_hit ? base_addr : line_addr;
    end else begin
      unique case (fetch_st)
        hco_pkg::FT_IDLE: ;
        hco_pkg::FT_FETCH: begin
          if (mem_rsp.ack) begin
            if (word_idx == width_f) begin
              fetch_st <= hco_pkg::FT_READY;
              mem_req <= 1'b0;
            end else begin
              word_idx <= word_idx + 2'b01;
              mem_addr <= mem_addr + 32'h0000_0004;
            end
          end
        end
        hco_pkg::FT_READY: begin
          if (show_q && (!show_on || last_col)) begin
            fetch_st <= hco_pkg::FT_IDLE;
          end
        end
      endcase
    end
  end

  // line buffer, one word per entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_buf
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          line_buf[gi] <= hco_pkg::RST_REG;
        end else if (fetch_st == hco_pkg::FT_FETCH && mem_rsp.ack && word_idx == 2'(gi)) begin
          line_buf[gi] <= mem_rsp.rdata;
        end
      end
    end
  endgenerate

  // start at x match on a valid pixel; an x never matched shows no cursor
  wire logic x_hit = fetch_st == hco_pkg::FT_READY && !show_q && vid_in.valid &&
                     vid_in.hcount == sh_x;
  wire logic [5:0] col_eff = show_q ? col : 6'h00;
  wire logic in_area = vid_in.hcount <= h_active_end && vid_in.vcount <= v_active_end;
  assign show_on = (show_q || x_hit) && vid_in.valid && in_area && sh_en;
  assign last_col = col_eff == {width_f, 4'hF};
  wire logic [1:0] code = line_buf[col_eff[5:4]][{col_eff[3:0], 1'b0} +: 2];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      show_q <= 1'b0;
      col <= 6'h00;
    end else if (vid_in.line_start || vid_in.frame_end) begin
      show_q <= 1'b0;
      col <= 6'h00;
    end else if (show_q && !show_on) begin
      show_q <= 1'b0;
    end else if (show_on) begin
      show_q <= !last_col;
      col <= col_eff + 6'h01;
    end
  end

  // blink phase flips every rate+1 frames
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      blink_cnt <= 8'h00;
      blink_phase <= 1'b0;
    end else if (!blink_ctl[hco_pkg::POS_BLINK_EN]) begin
      blink_cnt <= 8'h00;
      blink_phase <= 1'b0;
    end else if (vid_in.frame_end) begin
      if (blink_cnt == blink_ctl[7:0]) begin
        blink_cnt <= 8'h00;
        blink_phase <= !blink_phase;
      end else begin
        blink_cnt <= blink_cnt + 8'h01;
      end
    end
  end

  logic [23:0] next_pixel;
  always_comb begin
    next_pixel = vid_in.pixel;
    if (show_on) begin
      unique case (code)
        2'b00: next_pixel = vid_in.pixel;
        2'b01: next_pixel = ~vid_in.pixel;
        2'b10: next_pixel = blink_phase ? blink1 : color1;
        2'b11: next_pixel = blink_phase ? blink2 : color2;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_pixel <= hco_pkg::RST_COLOR;
    end else begin
      out_valid <= vid_in.valid;
      out_pixel <= next_pixel;
    end
  end

  a_transp_pass: assert property (@(posedge ref_clk) disable iff (!nrst)
    show_on && code == 2'b00 |=> out_pixel == $past(vid_in.pixel))
    else $error("transparent pixel altered");
  a_invert_bits: assert property (@(posedge ref_clk) disable iff (!nrst)
    show_on && code == 2'b01 |=> out_pixel == ~$past(vid_in.pixel))
    else $error("inverted pixel wrong");
  a_first_color: assert property (@(posedge ref_clk) disable iff (!nrst)
    show_on && code == 2'b10 && !blink_phase |=> out_pixel == $past(color1))
    else $error("first colour wrong");
  a_blink_second: assert property (@(posedge ref_clk) disable iff (!nrst)
    show_on && code == 2'b11 && blink_phase |=> out_pixel == $past(blink2))
    else $error("second blink colour wrong");
  a_enable_gate: assert property (@(posedge ref_clk) disable iff (!nrst)
    !sh_en |-> !show_on ##1 out_pixel == $past(vid_in.pixel))
    else $error("overlay while disabled");
  a_shadow_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    !vid_in.frame_end |=> $stable(sh_x) && $stable(sh_y) && $stable(sh_ly))
    else $error("position changed mid frame");
  a_clip_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
    vid_in.hcount > h_active_end || vid_in.vcount > v_active_end
    |=> out_pixel == $past(vid_in.pixel))
    else $error("cursor beyond active area");
  a_step_advance: assert property (@(posedge ref_clk) disable iff (!nrst)
    last_ack && !vid_in.frame_end && !(row_go && row_hit)
    |=> line_addr == $past(line_addr) + $past(step_bytes))
    else $error("line step wrong");
  a_second_color: assert property (@(posedge ref_clk) disable iff (!nrst)
    show_on && code == 2'b11 && !blink_phase |=> out_pixel == $past(color2))
    else $error("second colour wrong");
  a_fetch_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    mem_req && !mem_rsp.ack && !vid_in.frame_end |=> mem_req && $stable(mem_addr))
    else $error("memory request dropped or moved");

  c_cursor_shown: cover property (@(posedge ref_clk) disable iff (!nrst)
    show_on && last_col);
  c_blink_color: cover property (@(posedge ref_clk) disable iff (!nrst)
    show_on && blink_phase && code == 2'b10);
  c_dual_jump: cover property (@(posedge ref_clk) disable iff (!nrst)
    dual_scan && last_ack && row_cnt == height_lim && !lower_phase);
  c_dual_lower: cover property (@(posedge ref_clk) disable iff (!nrst)
    dual_scan && lower_phase && show_on);
  c_clip_right: cover property (@(posedge ref_clk) disable iff (!nrst)
    show_q && !in_area);
endmodule

// file: test/hco_mem_model.sv
module hco_mem_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  output hco_pkg::hco_mem_rsp_s mem_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] wait_cnt;
  function automatic logic [31:0] word_at(input logic [31:0] a);
    return (a * 32'h9e37_79b9) ^ 32'hc3a5_5a3c;
  endfunction
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mem_rsp <= '0;
      wait_cnt <= 3'h0;
    end else if (mem_rsp.ack || !mem_req) begin
      // idle data keeps moving, never a stale word
      mem_rsp.ack <= 1'b0;
      mem_rsp.rdata <= ~mem_rsp.rdata;
      wait_cnt <= 3'h0;
    end else if (wait_cnt >= (slow ? 3'h3 : 3'h0)) begin
      mem_rsp.ack <= 1'b1;
      mem_rsp.rdata <= word_at(mem_addr);
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
      mem_rsp.rdata <= ~mem_rsp.rdata;
    end
  end
endmodule

// file: test/hco_cursor_tb.sv
module hco_cursor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 48;
  localparam int NL = 6;
  localparam logic [10:0] HEND = 11'h027;
  localparam logic [10:0] VEND = 11'h004;
  localparam logic [31:0] DIMS_T [5] = '{32'h0002_0303, 32'h0005_0000, 32'h0000_0102,
    32'h0001_0203, 32'h0101_0000};
  localparam logic [31:0] POS_T [5] = '{32'h8001_0003, 32'h8003_001e, 32'h8000_0000,
    32'h8004_000c, 32'h8000_0005};
  localparam logic [31:0] OFF_T [5] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0004,
    32'h0000_0008, 32'h0000_0000};
  // lower half start line in the dual scan test
  localparam logic [10:0] LY = 11'h003;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic dscan = 1'b0;
  logic blk = 1'b0;
  logic bph = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, mem_addr, rd, start_a, dims, c1, c2, posen, act_pos, wrap_a, b1, b2;
  logic pready, pslverr, mem_req, out_valid, er;
  hco_pkg::hco_mem_rsp_s mem_rsp;
  hco_pkg::hco_vid_s vid_in = '0;
  logic [hco_pkg::PIX_W-1:0] out_pixel;
  logic [hco_pkg::PIX_W-1:0] exp_q [$];
  int error_cnt = 0;
  int samples_checked = 0;
  int seed = 32'hc36c;
  always #12.5 ref_clk = ~ref_clk;
  hco_cursor #(.ADDR_W(8)) u_dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rsp(mem_rsp), .vid_in(vid_in), .dual_scan(dscan), .h_active_end(HEND),
    .v_active_end(VEND), .out_valid(out_valid), .out_pixel(out_pixel));
  hco_mem_model u_mem (.ref_clk(ref_clk), .nrst(nrst), .slow(slow), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rsp(mem_rsp));
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic fail(input string msg);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input logic gerr,
      input logic eerr);
    samples_checked++;
    if (got !== exp || gerr !== eerr) fail("register access mismatch");
  endtask
  task automatic chk_pix(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) fail("pixel mismatch");
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail("bus timeout");
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic vid(input logic v, input logic ls, input logic fe, input int h, input int l,
      input logic [23:0] p);
    @(posedge ref_clk);
    vid_in <= '{v, ls, fe, h[10:0], l[10:0], p};
  endtask
  function automatic logic [23:0] expect_pix(input int h, input int l, input logic [23:0] p);
    int k, r, ht;
    logic [31:0] wd;
    k = h - int'(act_pos[10:0]);
    r = l - int'(act_pos[26:16]);
    ht = int'(dims[21:16]);
    wd = start_a;
    // lower half rows from wrap address
    if (dscan && l >= int'(LY)) begin
      r = l - int'(LY);
      ht = int'(dims[29:24]);
      wd = wrap_a;
    end
    if (act_pos[31] !== 1'b1 || k < 0 || k >= 16 * (int'(dims[9:8]) + 1) || r < 0
        || r > ht || h > int'(HEND) || l > int'(VEND)) return p;
    wd = wd + 32'(4 * r * (int'(dims[1:0]) + 1) + 4 * (k / 16));
    wd = (wd * 32'h9e37_79b9) ^ 32'hc3a5_5a3c;
    case (wd[2 * (k % 16) +: 2])
      2'b00: return p;
      2'b01: return ~p;
      2'b10: return bph ? b1[23:0] : c1[23:0];
      default: return bph ? b2[23:0] : c2[23:0];
    endcase
  endfunction
  task automatic frame();
    logic [23:0] pix;
    for (int l = 0; l < NL; l++) begin
      vid(1'b0, 1'b1, 1'b0, 0, l, 24'h00_0000);
      repeat (28) vid(1'b0, 1'b0, 1'b0, 0, l, 24'h00_0000);
      for (int h = 0; h < NP; h++) begin
        pix = 24'($random(seed));
        exp_q.push_back(expect_pix(h, l, pix));
        vid(1'b1, 1'b0, 1'b0, h, l, pix);
      end
    end
    vid(1'b0, 1'b0, 1'b1, 0, NL - 1, 24'h00_0000);
    act_pos = posen;
    // rate zero flips the phase every frame
    if (blk) bph = !bph;
    vid(1'b0, 1'b0, 1'b0, 0, 0, 24'h00_0000);
  endtask
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("unexpected pixel");
      end else begin
        chk_pix(out_pixel, exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    fail("run timeout");
    complete_run();
  end
  initial begin
    posen = 32'h0000_0000;
    act_pos = posen;
    dims = 32'h0000_0000;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    apb(1'b0, hco_pkg::OFS_POSEN, 32'h0000_0000);
    chk_reg(rd, hco_pkg::RST_REG, er, 1'b0);
    apb(1'b0, 8'h30, 32'h0000_0000);
    chk_reg(rd, 32'h0000_0000, er, 1'b1);
    apb(1'b1, hco_pkg::OFS_STATUS, 32'hffff_ffff);
    chk_reg(32'h0000_0000, 32'h0000_0000, er, 1'b1);
    frame();
    for (int t = 0; t < 5; t++) begin
      posen = posen & 32'h7fff_ffff;
      apb(1'b1, hco_pkg::OFS_POSEN, posen);
      frame();
      slow <= 1'($random(seed));
      start_a = ($random(seed) & 32'h0000_fff0) + OFF_T[t];
      wrap_a = start_a + ((t == 4) ? 32'h0000_0100 : 32'h0000_0000);
      c1 = $random(seed) & 32'h00ff_ffff;
      c2 = $random(seed) & 32'h00ff_ffff;
      dims = DIMS_T[t];
      posen = POS_T[t];
      apb(1'b1, hco_pkg::OFS_START, start_a);
      apb(1'b1, hco_pkg::OFS_WRAP, wrap_a);
      apb(1'b1, hco_pkg::OFS_DIMS, dims);
      apb(1'b1, hco_pkg::OFS_COLOR1, c1);
      apb(1'b1, hco_pkg::OFS_COLOR2, c2);
      apb(1'b1, hco_pkg::OFS_POSEN, posen);
      apb(1'b0, hco_pkg::OFS_START, 32'h0000_0000);
      chk_reg(rd, start_a, er, 1'b0);
      apb(1'b0, hco_pkg::OFS_DIMS, 32'h0000_0000);
      chk_reg(rd, dims, er, 1'b0);
      apb(1'b0, hco_pkg::OFS_WRAP, 32'h0000_0000);
      chk_reg(rd, wrap_a, er, 1'b0);
      if (t == 2) begin
        // blink colours, phase flips each frame
        b1 = $random(seed) & 32'h00ff_ffff;
        b2 = $random(seed) & 32'h00ff_ffff;
        blk = 1'b1;
        apb(1'b1, hco_pkg::OFS_BLINK1, b1);
        apb(1'b1, hco_pkg::OFS_BLINK2, b2);
        apb(1'b1, hco_pkg::OFS_BLINKCTL, 32'h0000_0100);
      end
      if (t == 4) begin
        // dual scan, lower rows start at LY
        dscan <= 1'b1;
        apb(1'b1, hco_pkg::OFS_LOWY, {21'h00_0000, LY});
        apb(1'b0, hco_pkg::OFS_LOWY, 32'h0000_0000);
        chk_reg(rd, {21'h00_0000, LY}, er, 1'b0);
      end
      frame();
      frame();
      $display("test %0d done", t);
    end
    for (int n = 0; n < 50 && exp_q.size() > 0; n++) @(posedge ref_clk);
    if (exp_q.size() > 0) fail("pixels missing");
    complete_run();
  end
endmodule
